// ### dac_par_device.sv
// Device end: parallel write capture, register banks and DAC load control
`timescale 1ns/1ns
module dac_par_device (
   // Clock and reset
   input  wire logic                           clock_i,
   input  wire logic                           nrst_i,
   // Straps
   input  wire logic                           interface_select_i,
   input  wire logic                           write_queue_enable_i,
   // Output view
   output logic [dac_par_pkg::DATA_W-1:0]      dac_code_o [dac_par_pkg::CH_N],
   output logic                                reference_ground_o,
   // Bus
   dac_par_if.device                           bus
);
   localparam int DW = dac_par_pkg::DATA_W;
   localparam int CN = dac_par_pkg::CH_N;
   localparam int QD = dac_par_pkg::QUEUE_DEPTH;
   typedef struct packed {
      logic [1:0]                     sel;
      logic [dac_par_pkg::ADDR_W-1:0] addr;
      logic [DW-1:0]                  data;
   } wr_ent_t;
   typedef enum logic [2:0] {
      S_RESET = 3'b001,
      S_IDLE  = 3'b010,
      S_CALC  = 3'b100
   } dev_t;

   dev_t                  st_ff;
   logic [DW-1:0]         code_ff   [CN];
   logic [DW-1:0]         gain_ff   [CN];
   logic [DW-1:0]         offset_ff [CN];
   logic [DW-1:0]         dac_ff    [CN];
   wr_ent_t               q_ff      [QD];
   logic [1:0]            q_wr_ff, q_rd_ff;
   logic [2:0]            q_cnt_ff;
   logic [3:0]            calc_cnt_ff;
   logic                  pend_ff, grounded_ff, busy_oe_ff, rst_cnt_ff;
   logic [1:0]            wr_s_ff, ld_s_ff, clr_s_ff, bsy_s_ff, cs_s_ff;
   logic                  wr_d_ff, ld_d_ff;
   logic                  wr_rise, ld_fall, clr_act, line_busy, q_pop, q_push, port_on;
   wr_ent_t               bus_ent, cur_ent;

   // Two-stage synchronisers, then a delayed copy for edges
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_s_ff  <= 2'b11;
         ld_s_ff  <= 2'b11;
         clr_s_ff <= 2'b11;
         bsy_s_ff <= 2'b11;
         cs_s_ff  <= 2'b11;
         wr_d_ff  <= 1'b1;
         ld_d_ff  <= 1'b1;
      end else begin
         wr_s_ff  <= {wr_s_ff[0], bus.wr_n};
         ld_s_ff  <= {ld_s_ff[0], bus.load_dac_strobe_n};
         clr_s_ff <= {clr_s_ff[0], bus.output_clear_n};
         bsy_s_ff <= {bsy_s_ff[0], bus.busy_line};
         // Select shares the strobe's delay; host may lift it before the edge is seen
         cs_s_ff  <= {cs_s_ff[0], bus.cs_n};
         wr_d_ff  <= wr_s_ff[1];
         ld_d_ff  <= ld_s_ff[1];
      end
   end

   // Data/address held stable by host around the strobe; sampled at sync edge
   assign bus_ent   = '{sel: {bus.reg_type_sel_hi, bus.reg_type_sel_lo},
                        addr: bus.parallel_addr_in, data: bus.parallel_data_in};
   assign port_on   = !interface_select_i && st_ff != S_RESET;
   assign wr_rise   = wr_s_ff[1] && !wr_d_ff && !cs_s_ff[1] && port_on;
   assign ld_fall   = !ld_s_ff[1] && ld_d_ff && st_ff != S_RESET;
   assign clr_act   = !clr_s_ff[1];
   assign line_busy = !bsy_s_ff[1];
   assign q_push    = wr_rise && write_queue_enable_i && (st_ff == S_CALC || q_cnt_ff != 3'h0);
   // Drain waits for our own busy echo to leave the synchroniser
   assign q_pop     = st_ff == S_IDLE && q_cnt_ff != 3'h0 && !line_busy;
   assign cur_ent   = q_pop ? q_ff[q_rd_ff] : bus_ent;

   // Write queue; without enable, writes arriving mid-calculation are dropped
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_wr_ff  <= 2'h0;
         q_rd_ff  <= 2'h0;
         q_cnt_ff <= 3'h0;
      end else begin
         if (q_push && q_cnt_ff != 3'(QD)) begin
            q_ff[q_wr_ff] <= bus_ent;
            q_wr_ff       <= q_wr_ff + 2'h1;
         end
         if (q_pop)
            q_rd_ff <= q_rd_ff + 2'h1;
         q_cnt_ff <= q_cnt_ff + 3'((q_push && q_cnt_ff != 3'(QD)) ? 1 : 0)
                     - 3'(q_pop ? 1 : 0);
      end
   end

   // Apply a write to the addressed channel (group 0 = all channels)
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < CN; i++) begin
            code_ff[i]   <= dac_par_pkg::DATA_RST;
            gain_ff[i]   <= dac_par_pkg::GAIN_RST;
            offset_ff[i] <= dac_par_pkg::OFFSET_RST;
         end
      end else if (q_pop || (wr_rise && !q_push && st_ff == S_IDLE)) begin
         for (int i = 0; i < CN; i++) begin
            if (cur_ent.addr[dac_par_pkg::GRP_HI:dac_par_pkg::GRP_LO] == 4'h0 ||
                (cur_ent.addr[dac_par_pkg::GRP_HI:dac_par_pkg::GRP_LO] == 4'(i / 8 + 1) &&
                 cur_ent.addr[2:0] == 3'(i % 8))) begin
               unique case (cur_ent.sel)
                  dac_par_pkg::SEL_DATA:   code_ff[i]   <= cur_ent.data;
                  dac_par_pkg::SEL_GAIN:   gain_ff[i]   <= cur_ent.data;
                  dac_par_pkg::SEL_OFFSET: offset_ff[i] <= cur_ent.data;
                  dac_par_pkg::SEL_SPECIAL:
                     if (cur_ent.data == dac_par_pkg::SOFT_RESET_CODE) begin
                        code_ff[i]   <= dac_par_pkg::DATA_RST;
                        gain_ff[i]   <= dac_par_pkg::GAIN_RST;
                        offset_ff[i] <= dac_par_pkg::OFFSET_RST;
                     end else
                        code_ff[i] <= code_ff[i] + cur_ent.data;   // Increment mode
               endcase
            end
         end
      end
   end

   // Control: reset hold, calculation after each write, pending load
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff       <= S_RESET;
         rst_cnt_ff  <= 1'b0;
         calc_cnt_ff <= 4'h0;
         pend_ff     <= 1'b0;
         busy_oe_ff  <= 1'b1;
      end else begin
         unique case (st_ff)
            S_RESET: begin
               rst_cnt_ff <= 1'b1;
               if (rst_cnt_ff) begin
                  st_ff      <= S_IDLE;
                  busy_oe_ff <= 1'b0;
               end
            end
            S_IDLE:
               if (q_pop || (wr_rise && st_ff == S_IDLE)) begin
                  st_ff       <= S_CALC;
                  busy_oe_ff  <= 1'b1;
                  calc_cnt_ff <= 4'(dac_par_pkg::CALC_CYCLES - 1);
               end
            S_CALC:
               if (calc_cnt_ff == 4'h0) begin
                  st_ff      <= S_IDLE;
                  busy_oe_ff <= 1'b0;
               end else
                  calc_cnt_ff <= calc_cnt_ff - 4'h1;
         endcase
         // Store load seen while busy; act once line is released and the queue is empty
         if (ld_fall && !clr_act && (line_busy || st_ff != S_IDLE))
            pend_ff <= 1'b1;
         else if (st_ff == S_IDLE && !line_busy && !q_pop)
            pend_ff <= 1'b0;
      end
   end

   // DAC registers and clear; clear never touches register contents
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < CN; i++)
            dac_ff[i] <= dac_par_pkg::DATA_RST;
         grounded_ff <= 1'b1;
      end else begin
         if (clr_act)
            grounded_ff <= 1'b1;
         else if (st_ff == S_IDLE && !line_busy && !q_pop &&
                  (pend_ff || ld_fall)) begin
            for (int i = 0; i < CN; i++)
               dac_ff[i] <= code_ff[i];
            grounded_ff <= 1'b0;
         end
      end
   end

   assign dac_code_o         = dac_ff;
   assign reference_ground_o = grounded_ff;
   assign bus.busy_dev_oe    = busy_oe_ff;
endmodule

// ### dac_par_pkg.sv
// Shared constants for the parallel DAC load port
package dac_par_pkg;
   localparam int DATA_W      = 14;
   localparam int ADDR_W      = 8;
   localparam int CH_N        = 32;
   localparam int GRP_HI      = 7;
   localparam int GRP_LO      = 4;
   localparam int CALC_CYCLES = 8;
   localparam int QUEUE_DEPTH = 4;
   localparam logic [DATA_W-1:0] GAIN_RST   = 14'h3fff;
   localparam logic [DATA_W-1:0] OFFSET_RST = 14'h2000;
   localparam logic [DATA_W-1:0] DATA_RST   = 14'h0000;
   localparam logic [1:0] SEL_SPECIAL = 2'h0;
   localparam logic [1:0] SEL_GAIN    = 2'h1;
   localparam logic [1:0] SEL_OFFSET  = 2'h2;
   localparam logic [1:0] SEL_DATA    = 2'h3;
   localparam logic [DATA_W-1:0] SOFT_RESET_CODE = 14'h0000;
endpackage

// ### dac_par_if.sv
// Parallel bus between host and DAC load control
`timescale 1ns/1ns
interface dac_par_if;
   logic                           cs_n;
   logic                           wr_n;
   logic [dac_par_pkg::DATA_W-1:0] parallel_data_in;
   logic [dac_par_pkg::ADDR_W-1:0] parallel_addr_in;
   logic                           reg_type_sel_lo;
   logic                           reg_type_sel_hi;
   logic                           output_clear_n;
   logic                           load_dac_strobe_n;
   logic                           busy_dev_oe;
   logic                           busy_host_oe;
   logic                           busy_line;
   // Open-drain wire with external pull-up
   assign busy_line = !(busy_dev_oe || busy_host_oe);
   modport device (input cs_n, wr_n, parallel_data_in, parallel_addr_in, reg_type_sel_lo,
                   reg_type_sel_hi, output_clear_n, load_dac_strobe_n, busy_line,
                   output busy_dev_oe);
   modport host (output cs_n, wr_n, parallel_data_in, parallel_addr_in, reg_type_sel_lo,
                 reg_type_sel_hi, output_clear_n, load_dac_strobe_n, busy_host_oe,
                 input busy_line);
endinterface

// ### dac_par_host.sv
// Host end: drives parallel writes, load strobe, clear and busy hold
`timescale 1ns/1ns
module dac_par_host (
   // Clock and reset
   input  wire logic                           clock_i,
   input  wire logic                           nrst_i,
   // User write request
   input  wire logic                           wr_req_i,
   input  wire logic [dac_par_pkg::ADDR_W-1:0] wr_addr_i,
   input  wire logic [1:0]                     wr_sel_i,
   input  wire logic [dac_par_pkg::DATA_W-1:0] wr_data_i,
   // User load, clear and hold controls
   input  wire logic                           load_req_i,
   input  wire logic                           clear_i,
   input  wire logic                           hold_busy_i,
   // Status
   output logic                                wr_done_o,
   output logic                                busy_o,
   // Bus
   dac_par_if.host                             bus
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_LOW  = 3'b010,
      H_HIGH = 3'b100
   } hst_t;
   hst_t st_ff;
   logic cs_n_ff, wr_n_ff, ld_n_ff, clr_n_ff, hold_ff, done_ff, busy_ff;
   logic [dac_par_pkg::DATA_W-1:0] data_ff;
   logic [dac_par_pkg::ADDR_W-1:0] addr_ff;
   logic [1:0]                     sel_ff;

   // Write cycle: assert select and strobe low, then rising strobe commits
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff   <= H_IDLE;
         cs_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         done_ff <= 1'b0;
         data_ff <= '0;
         addr_ff <= '0;
         sel_ff  <= 2'h0;
      end else begin
         done_ff <= 1'b0;
         unique case (st_ff)
            H_IDLE: if (wr_req_i) begin
               cs_n_ff <= 1'b0;
               wr_n_ff <= 1'b0;
               data_ff <= wr_data_i;
               addr_ff <= wr_addr_i;
               sel_ff  <= wr_sel_i;
               st_ff   <= H_LOW;
            end
            H_LOW: begin
               wr_n_ff <= 1'b1;
               st_ff   <= H_HIGH;
            end
            H_HIGH: begin
               cs_n_ff <= 1'b1;
               done_ff <= 1'b1;
               st_ff   <= H_IDLE;
            end
         endcase
      end
   end

   // Load strobe is low for each cycle load_req_i is high; clear and hold follow the user
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ld_n_ff  <= 1'b1;
         clr_n_ff <= 1'b1;
         hold_ff  <= 1'b0;
         busy_ff  <= 1'b0;
      end else begin
         ld_n_ff  <= !load_req_i;
         clr_n_ff <= !clear_i;
         hold_ff  <= hold_busy_i;
         busy_ff  <= !bus.busy_line;
      end
   end

   assign bus.cs_n              = cs_n_ff;
   assign bus.wr_n              = wr_n_ff;
   assign bus.parallel_data_in  = data_ff;
   assign bus.parallel_addr_in  = addr_ff;
   assign bus.reg_type_sel_lo   = sel_ff[0];
   assign bus.reg_type_sel_hi   = sel_ff[1];
   assign bus.load_dac_strobe_n = ld_n_ff;
   assign bus.output_clear_n    = clr_n_ff;
   assign bus.busy_host_oe      = hold_ff;
   assign wr_done_o             = done_ff;
   assign busy_o                = busy_ff;
endmodule

// ### dac_par_properties.sv
// Interface-level properties of the parallel DAC load port
`timescale 1ns/1ns
module dac_par_properties (
   // Clock and reset
   input wire logic                           clock_i,
   input wire logic                           nrst_i,
   // Parallel bus and busy wire
   input wire logic                           cs_n,
   input wire logic                           wr_n,
   input wire logic [dac_par_pkg::DATA_W-1:0] parallel_data_in,
   input wire logic [dac_par_pkg::ADDR_W-1:0] parallel_addr_in,
   input wire logic                           reg_type_sel_lo,
   input wire logic                           reg_type_sel_hi,
   input wire logic                           output_clear_n,
   input wire logic                           load_dac_strobe_n,
   input wire logic                           busy_dev_oe,
   input wire logic                           busy_host_oe,
   input wire logic                           busy_line,
   // Strap
   input wire logic                           interface_select_i
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   // Saturating, so a stuck busy cannot wrap back into the legal range
   logic [6:0] busy_run_ff;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_run_ff <= 7'h00;
      end else if (!busy_dev_oe) begin
         busy_run_ff <= 7'h00;
      end else if (busy_run_ff != 7'h7f) begin
         busy_run_ff <= busy_run_ff + 7'h01;
      end
   end
   a_reset_busy_low: assert property ($rose(nrst_i) |-> busy_dev_oe)
      else $error("busy not driven at reset release");
   a_host_idle_reset: assert property ($rose(nrst_i) |-> cs_n && wr_n && output_clear_n)
      else $error("host strobes not idle after reset");
   a_write_sets_busy: assert property ($rose(wr_n) && !cs_n && !interface_select_i
      |-> ##[1:6] busy_dev_oe)
      else $error("captured write did not start a calculation");
   a_busy_min_span: assert property ($rose(busy_dev_oe) |-> busy_dev_oe [*8])
      else $error("calculation busy shorter than expected");
   a_busy_bounded: assert property (busy_run_ff <= 7'h40)
      else $error("busy held far beyond queue drain time");
   a_write_in_select: assert property (!wr_n |-> !cs_n)
      else $error("write strobe low without chip select");
   a_bus_held: assert property ($rose(wr_n) |=> $stable(parallel_data_in)
      && $stable(parallel_addr_in) && $stable({reg_type_sel_hi, reg_type_sel_lo}))
      else $error("bus changed right after write edge");
   a_load_pulse: assert property ($fell(load_dac_strobe_n) |=> $rose(load_dac_strobe_n))
      else $error("load strobe not a one cycle pulse");
   a_hold_pulls_low: assert property (busy_host_oe |-> !busy_line)
      else $error("held busy wire not low");
   c_write: cover property ($rose(wr_n) && !cs_n);
   c_load_busy: cover property (!load_dac_strobe_n && !busy_line);
   c_load_clear: cover property (!load_dac_strobe_n && !output_clear_n);
endmodule

// ### testbench.sv
// Self-checking bench joining host and device ends of the parallel DAC port
`timescale 1ns/1ns
module testbench;
   typedef struct packed {
      logic [4:0]  ch;
      logic [13:0] code;
      logic        gnd;
   } note_t;
   logic                           clock_i, nrst_i, wr_req_i, load_req_i, clear_i;
   logic                           hold_busy_i, queue_en, wr_done_o, busy_o, interface_sel;
   logic                           reference_ground_o, snap_gnd;
   logic [dac_par_pkg::ADDR_W-1:0] wr_addr_i;
   logic [1:0]                     wr_sel_i;
   logic [dac_par_pkg::DATA_W-1:0] wr_data_i, data;
   logic [dac_par_pkg::DATA_W-1:0] dac_code_o [dac_par_pkg::CH_N];
   logic [dac_par_pkg::DATA_W-1:0] snap [dac_par_pkg::CH_N];
   logic [dac_par_pkg::DATA_W-1:0] inp [dac_par_pkg::CH_N];
   logic [dac_par_pkg::DATA_W-1:0] model [dac_par_pkg::CH_N];
   logic [4:0]                     ch, chs [3];
   note_t                          notes [$];
   note_t                          n;
   int                             bad_count = 0;
   int                             num_checks = 0;
   int                             i, k;
   dac_par_if bus ();
   dac_par_host dac_par_host_i (.clock_i(clock_i), .nrst_i(nrst_i), .wr_req_i(wr_req_i),
      .wr_addr_i(wr_addr_i), .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i),
      .load_req_i(load_req_i), .clear_i(clear_i), .hold_busy_i(hold_busy_i),
      .wr_done_o(wr_done_o), .busy_o(busy_o), .bus(bus));
   dac_par_device dac_par_device_i (.clock_i(clock_i), .nrst_i(nrst_i),
      .interface_select_i(interface_sel), .write_queue_enable_i(queue_en),
      .dac_code_o(dac_code_o),
      .reference_ground_o(reference_ground_o), .bus(bus));
   dac_par_properties dac_par_properties_i (.clock_i(clock_i), .nrst_i(nrst_i),
      .cs_n(bus.cs_n), .wr_n(bus.wr_n), .parallel_data_in(bus.parallel_data_in),
      .parallel_addr_in(bus.parallel_addr_in), .reg_type_sel_lo(bus.reg_type_sel_lo),
      .reg_type_sel_hi(bus.reg_type_sel_hi), .output_clear_n(bus.output_clear_n),
      .load_dac_strobe_n(bus.load_dac_strobe_n), .busy_dev_oe(bus.busy_dev_oe),
      .busy_host_oe(bus.busy_host_oe), .busy_line(bus.busy_line),
      .interface_select_i(interface_sel));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cycles(input int cnt);
      repeat (cnt) @(posedge clock_i);
   endtask
   // Busy must stay released for a while, as queued writes restart it
   task automatic wait_idle();
      int quiet = 0;
      for (int g = 0; g < 800 && quiet < 12; g++) begin
         @(posedge clock_i);
         quiet = (busy_o === 1'b0) ? quiet + 1 : 0;
      end
      check(14'(quiet >= 12), 14'h0001);
   endtask
   task automatic do_write(input logic [4:0] c, input logic [13:0] d, input logic group,
                           input logic [1:0] sel);
      wr_addr_i <= group ? {({2'h0, c[4:3]} + 4'h1), 1'b0, c[2:0]} : 8'h05;
      wr_sel_i <= sel;
      wr_data_i <= d;
      wr_req_i <= 1'b1;
      @(posedge clock_i);
      wr_req_i <= 1'b0;
      for (int g = 0; g < 20 && wr_done_o !== 1'b1; g++) @(posedge clock_i);
      check(14'(wr_done_o), 14'h0001);
   endtask
   task automatic do_load(input int post);
      load_req_i <= 1'b1;
      @(posedge clock_i);
      load_req_i <= 1'b0;
      cycles(post);
   endtask
   task automatic tally_and_finish();
      check(14'(notes.size()), 14'h0000);
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Any change on the output view out of reset consumes the oldest expectation
   always @(posedge clock_i) begin
      if (nrst_i === 1'b1 && (dac_code_o != snap || reference_ground_o !== snap_gnd)) begin
         n = (notes.size() > 0) ? notes.pop_front() : '{5'h00, 14'h3fff, 1'bx};
         check(dac_code_o[n.ch], n.code);
         check(14'(reference_ground_o), 14'(n.gnd));
      end
      snap = dac_code_o;
      snap_gnd = reference_ground_o;
   end
   initial begin
      cycles(20000);
      bad_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      void'($urandom(45));
      {nrst_i, wr_req_i, load_req_i, clear_i, hold_busy_i, queue_en, interface_sel} = 7'h00;
      {wr_addr_i, wr_sel_i, wr_data_i} = 24'h000000;
      foreach (inp[j]) inp[j] = dac_par_pkg::DATA_RST;
      model = inp;
      cycles(20);
      nrst_i <= 1'b1;
      cycles(6);
      check(14'(reference_ground_o), 14'h0001);
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         ch = 5'($urandom_range(31));
         data = {1'b1, 13'($urandom)};
         do_write(ch, data, 1'b1, dac_par_pkg::SEL_DATA);
         inp[ch] = data;
         if (i < 3) begin
            wait_idle();
         end else begin
            for (k = 0; k < 20 && busy_o !== 1'b1; k++) @(posedge clock_i);
         end
         if (i == 5) begin
            // A held line never goes quiet, so the calculation is waited out by count
            hold_busy_i <= 1'b1;
            cycles(20);
            do_load(12);
            check(dac_code_o[ch], model[ch]);
            hold_busy_i <= 1'b0;
         end else begin
            do_load(2);
         end
         model = inp;
         notes.push_back('{ch, data, 1'b0});
         wait_idle();
      end
      $display("test load idle busy and hold done");
      notes.push_back('{ch, model[ch], 1'b1});
      clear_i <= 1'b1;
      cycles(4);
      data = ~model[ch];
      do_write(ch, data, 1'b1, dac_par_pkg::SEL_DATA);
      inp[ch] = data;
      wait_idle();
      do_load(12);
      clear_i <= 1'b0;
      cycles(12);
      check(14'(reference_ground_o), 14'h0001);
      check(dac_code_o[ch], model[ch]);
      model = inp;
      notes.push_back('{ch, data, 1'b0});
      do_load(12);
      $display("test clear done");
      data = 14'($urandom);
      do_write(5'h00, data, 1'b0, dac_par_pkg::SEL_DATA);
      foreach (inp[j]) inp[j] = data;
      wait_idle();
      notes.push_back('{5'h1f, data, 1'b0});
      do_load(12);
      for (k = 0; k < dac_par_pkg::CH_N; k++) check(dac_code_o[k], data);
      model = inp;
      $display("test broadcast done");
      // Gain and offset leave the code alone; the special type adds or soft-resets
      data = 14'($urandom_range(1000)) + 14'h0001;
      do_write(ch, data, 1'b1, dac_par_pkg::SEL_GAIN);
      wait_idle();
      do_write(ch, data, 1'b1, dac_par_pkg::SEL_OFFSET);
      wait_idle();
      do_write(ch, data, 1'b1, dac_par_pkg::SEL_SPECIAL);
      wait_idle();
      inp[ch] = model[ch] + data;
      model = inp;
      notes.push_back('{ch, model[ch], 1'b0});
      do_load(12);
      check(dac_code_o[ch], model[ch]);
      do_write(5'h00, dac_par_pkg::SOFT_RESET_CODE, 1'b0, dac_par_pkg::SEL_SPECIAL);
      wait_idle();
      foreach (inp[j]) inp[j] = dac_par_pkg::DATA_RST;
      model = inp;
      notes.push_back('{ch, model[ch], 1'b0});
      do_load(12);
      check(dac_code_o[~ch], dac_par_pkg::DATA_RST);
      // Serial strap set: the same write must not land or start a calculation
      interface_sel <= 1'b1;
      do_write(ch, ~model[ch], 1'b1, dac_par_pkg::SEL_DATA);
      cycles(4);
      check(14'(busy_o), 14'h0000);
      do_load(12);
      check(dac_code_o[ch], model[ch]);
      interface_sel <= 1'b0;
      $display("test register types and strap done");
      for (i = 0; i < 2; i++) begin
         queue_en <= i[0];
         for (k = 0; k < 3; k++) begin
            chs[k] = 5'(k * 8) + 5'($urandom_range(7));
            data = {1'b0, 13'($urandom)};
            do_write(chs[k], data, 1'b1, dac_par_pkg::SEL_DATA);
            if (k == 0 || i == 1) inp[chs[k]] = data;
         end
         wait_idle();
         model = inp;
         notes.push_back('{chs[0], model[chs[0]], 1'b0});
         do_load(12);
         for (k = 1; k < 3; k++) check(dac_code_o[chs[k]], model[chs[k]]);
      end
      $display("test write queue done");
      nrst_i <= 1'b0;
      cycles(3);
      check(14'(reference_ground_o), 14'h0001);
      check(dac_code_o[chs[0]], dac_par_pkg::DATA_RST);
      nrst_i <= 1'b1;
      cycles(8);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
